//--- hw/pcpd_regs.svh
// Timing and configuration constants for the PLL control model.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef PCPD_REGS_SVH
`define PCPD_REGS_SVH

// Divider factor limits
`define PCPD_DIV_MIN        7'h01
`define PCPD_DIV_MAX        7'h40
// Clock period and lock time, both in nanoseconds
`define PCPD_CLK_PERIOD_NS  10
`define PCPD_LOCK_TIME_NS   20000
// Longest time, rounded down to whole cycles
`define PCPD_LOCK_CYCLES    ((`PCPD_LOCK_TIME_NS) / (`PCPD_CLK_PERIOD_NS))
// Phase delay step and span in picoseconds
`define PCPD_DELAY_STEP_PS  250
`define PCPD_DELAY_MAX_PS   3750
// Reset values
`define PCPD_DELAY_RST      5'h00
`define PCPD_PERIOD_RST     16'h0000

`endif

//--- hw/pcpd_pkg.sv
// Types shared by the PLL control model.
// Assumes nothing beyond the constants header.
package pcpd_pkg;

  // Loop configuration driven by user core logic
  typedef struct packed {
    logic [6:0] fbDiv;        // Feedback factor, 1..64
    logic [6:0] outDiv;       // Output factor, 1..64
    logic [2:0] rangeCode;    // Output range code
    logic       lowBandFlag;  // High for low-band reference
    logic       feedbackSel;  // High selects external feedback
  } pcpd_cfg_t;

  // Decoded output band
  typedef enum logic [2:0] {
    BAND_400_1000,
    BAND_200_400,
    BAND_100_200,
    BAND_50_100,
    BAND_20_50
  } pcpd_band_t;

  // Lock sequencer
  typedef enum logic [1:0] {
    ST_OFF,
    ST_ACQUIRE,
    ST_LOCKED
  } pcpd_state_t;

endpackage

//--- hw/pcpd_divider.sv
// Output divider: toggles its output every outDiv half-period ticks.
// Assumes ticks are one-cycle pulses on the same clock.
`timescale 1ns/1ns
`include "pcpd_regs.svh"
module pcpd_divider
  import pcpd_pkg::*;
#(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Control
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] div,
  // Output
  output logic              dividedOut
);

  logic [W-1:0] cnt_q;     // Ticks since last toggle
  logic [W-1:0] cnt_d;
  logic         out_q;     // Divided clock level
  logic         out_d;

  // Next count and level
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (clear) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (tick) begin
      if (cnt_q >= div - W'(1)) begin
        cnt_d = '0;
        out_d = ~out_q;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  // Registers, frozen while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign dividedOut = out_q;

  // Toggle after exactly div ticks
  AST_DIV_TOGGLE: assert property (@(posedge clk) disable iff (!nrst)
    ce && !clear && tick && cnt_q == div - W'(1) |=> out_q != $past(out_q))
    else $error("divided output missed its toggle");

endmodule

//--- hw/pcpd_top.sv
// PLL control model: dividers, lock sequencing, feedback mux, phase delay.
// Assumes configuration inputs come from logic on clk; refIn and
// externalFeedbackIn are pins and are synchronised here.
// Functional notes
// - Divider factors only 1 to 64
// - Output equals reference times i over j
// - Delay spans -3.75 to 3.75 ns, 250ps steps
// - Static delay frozen after configuration
// - Dynamic delay code follows port while running
// - Lock within 20 us of enable
// - Power enable active high, low shuts down
// - Select external or internal feedback, never both
// - Range code selects output frequency band
// - Low four code bits count 250ps steps
// - Code MSB sets sign, one is negative
// - Separate delay lines at feedback and reference
// - Divided output i/j, multiplied output times i
// - Lock output rises once loop locks
`timescale 1ns/1ns
`include "pcpd_regs.svh"
module pcpd_top
  import pcpd_pkg::*;
#(
  parameter int PW = 16                  // Reference period counter width
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Pins
  input  wire logic        refIn,
  input  wire logic        externalFeedbackIn,
  // Configuration from core logic
  input  wire logic        powerEnable,
  input  pcpd_cfg_t        cfg,
  input  wire logic        dynamicDelayMode,
  input  wire logic [4:0]  delayCode,
  // Clock outputs
  output logic             dividedOutput,
  output logic             multipliedOutput,
  output logic             feedbackToCore,
  // Status
  output logic             lockOut,
  output logic             cfgError,
  output pcpd_band_t       outputBand,
  output logic             lowBandMode,
  // Delay line settings in picoseconds
  output logic [11:0]      refDelayPs,
  output logic [11:0]      fbDelayPs,
  output logic signed [12:0] appliedDelayPs
);

  localparam int LOCK_CYCLES = `PCPD_LOCK_CYCLES;
  localparam logic [11:0] LOCK_LAST = 12'(LOCK_CYCLES - 1);

  // Divider factor legality
  function automatic logic divOk(input logic [6:0] f);
    return (f >= `PCPD_DIV_MIN) && (f <= `PCPD_DIV_MAX);
  endfunction

  // Step count to picoseconds
  function automatic logic [11:0] stepsToPs(input logic [3:0] s);
    return 12'(s) * 12'(`PCPD_DELAY_STEP_PS);
  endfunction

  // Range code decode, bit 0 low means top band
  function automatic pcpd_band_t bandOf(input logic [2:0] c);
    pcpd_band_t b;
    b = BAND_400_1000;
    if (c[0]) begin
      unique case (c[2:1])
        2'h0: b = BAND_200_400;
        2'h1: b = BAND_100_200;
        2'h2: b = BAND_50_100;
        2'h3: b = BAND_20_50;
      endcase
    end
    return b;
  endfunction

  // Pin synchronisers, first stages read only by second stages
  logic [1:0] refSync_q;           // Reference pin pipeline
  logic [1:0] fbSync_q;            // External feedback pipeline
  logic       refLast_q;           // Previous synced reference
  logic       cfgValid;            // Both factors legal
  logic       refEdge;             // Synced reference rising edge

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      refSync_q <= 2'h0;
      fbSync_q  <= 2'h0;
      refLast_q <= 1'b0;
    end else if (ce) begin
      refSync_q <= {refSync_q[0], refIn};
      fbSync_q  <= {fbSync_q[0], externalFeedbackIn};
      refLast_q <= refSync_q[1];
    end
  end

  assign refEdge  = refSync_q[1] & ~refLast_q;
  assign cfgValid = divOk(cfg.fbDiv) && divOk(cfg.outDiv);

  // Loop state
  pcpd_state_t   state_q, state_d;     // Lock sequencer
  logic [11:0]   lockCnt_q, lockCnt_d; // Acquisition cycle count
  logic [PW-1:0] perCnt_q, perCnt_d;   // Cycles since reference edge
  logic [PW-1:0] period_q, period_d;   // Measured reference period
  logic          refSeen_q, refSeen_d; // A reference period is known
  logic [PW:0]   acc_q, acc_d;         // Oscillator phase accumulator
  logic          mult_q, mult_d;       // Multiplied clock level
  logic          fbSel_q, fbSel_d;     // Mux output to the core
  logic          fbLast_q, fbLast_d;   // Previous mux output
  logic          fbSeen_q, fbSeen_d;   // Feedback activity seen
  logic          tick;                 // Half-period tick
  logic          running;              // Oscillator allowed to run

  assign running = (state_q != ST_OFF) && refSeen_q;

  // Next loop state
  always_comb begin
    state_d   = state_q;
    lockCnt_d = lockCnt_q;
    perCnt_d  = perCnt_q;
    period_d  = period_q;
    refSeen_d = refSeen_q;
    acc_d     = acc_q;
    mult_d    = mult_q;
    tick      = 1'b0;
    // Mux picks exactly one feedback source
    fbSel_d   = cfg.feedbackSel ? fbSync_q[1] : mult_q;
    fbLast_d  = fbSel_q;
    fbSeen_d  = fbSeen_q | (fbSel_q ^ fbLast_q);
    // Reference period measurement
    if (refEdge) begin
      period_d  = perCnt_q + PW'(1);
      perCnt_d  = '0;
      refSeen_d = 1'b1;
    end else if (perCnt_q != '1) begin
      perCnt_d = perCnt_q + PW'(1);
    end
    // Oscillator: 2*i half periods per reference period
    if (running) begin
      acc_d = acc_q + (PW+1)'({cfg.fbDiv, 1'b0});
      if (acc_d >= {1'b0, period_q}) begin
        acc_d  = acc_d - {1'b0, period_q};
        tick   = 1'b1;
        mult_d = ~mult_q;
      end
    end
    // Lock sequencing
    unique case (state_q)
      ST_OFF: begin
        lockCnt_d = '0;
        if (powerEnable && cfgValid && refSeen_q) begin
          state_d = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (lockCnt_q < LOCK_LAST) begin
          lockCnt_d = lockCnt_q + 12'h001;
        end else if (fbSeen_q) begin
          state_d = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        lockCnt_d = lockCnt_q;
      end
    endcase
    // Shutdown wins, clears sequencer, count and oscillator for a fresh acquisition
    if (!powerEnable || !cfgValid) begin
      state_d   = ST_OFF;
      lockCnt_d = '0;
      acc_d     = '0;
      mult_d    = 1'b0;
      fbSeen_d  = 1'b0;
      tick      = 1'b0;
    end
  end

  // Loop registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= ST_OFF;
      lockCnt_q <= '0;
      perCnt_q  <= '0;
      period_q  <= `PCPD_PERIOD_RST;
      refSeen_q <= 1'b0;
      acc_q     <= '0;
      mult_q    <= 1'b0;
      fbSel_q   <= 1'b0;
      fbLast_q  <= 1'b0;
      fbSeen_q  <= 1'b0;
    end else if (ce) begin
      state_q   <= state_d;
      lockCnt_q <= lockCnt_d;
      perCnt_q  <= perCnt_d;
      period_q  <= period_d;
      refSeen_q <= refSeen_d;
      acc_q     <= acc_d;
      mult_q    <= mult_d;
      fbSel_q   <= fbSel_d;
      fbLast_q  <= fbLast_d;
      fbSeen_q  <= fbSeen_d;
    end
  end

  // Output divider by j
  pcpd_divider #(.W(7)) uDiv (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .clear      (!powerEnable || !cfgValid),
    .tick       (tick),
    .div        (cfg.outDiv),
    .dividedOut (dividedOutput)
  );

  assign multipliedOutput = mult_q;
  assign feedbackToCore   = fbSel_q;
  assign lockOut          = (state_q == ST_LOCKED);

  // Delay and status state
  logic [4:0]  heldCode_q, heldCode_d;   // Static code captured once
  logic        taken_q, taken_d;         // Static capture done
  logic [4:0]  useCode;                  // Code in force
  logic [11:0] refDly_q, refDly_d;       // Reference-side line
  logic [11:0] fbDly_q, fbDly_d;         // Feedback-side line
  logic signed [12:0] appl_q, appl_d;    // Signed applied delay
  logic        err_q, err_d;             // Illegal divider factor
  pcpd_band_t  band_q, band_d;           // Decoded band
  logic        low_q, low_d;             // Low-band mode held

  // Next delay and status values
  always_comb begin
    heldCode_d = heldCode_q;
    taken_d    = 1'b1;
    if (!taken_q) begin
      heldCode_d = delayCode;
    end
    useCode  = dynamicDelayMode ? delayCode : heldCode_d;
    refDly_d = 12'h000;
    fbDly_d  = 12'h000;
    // Lag at the reference input, lead via the feedback loop
    if (useCode[4]) begin
      fbDly_d = stepsToPs(useCode[3:0]);
      appl_d  = -$signed({1'b0, fbDly_d});
    end else begin
      refDly_d = stepsToPs(useCode[3:0]);
      appl_d   = $signed({1'b0, refDly_d});
    end
    err_d  = !cfgValid;
    band_d = bandOf(cfg.rangeCode);
    low_d  = cfg.lowBandFlag;
  end

  // Delay and status registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      heldCode_q <= `PCPD_DELAY_RST;
      taken_q    <= 1'b0;
      refDly_q   <= 12'h000;
      fbDly_q    <= 12'h000;
      appl_q     <= 13'sh0000;
      err_q      <= 1'b0;
      band_q     <= BAND_400_1000;
      low_q      <= 1'b0;
    end else if (ce) begin
      heldCode_q <= heldCode_d;
      taken_q    <= taken_d;
      refDly_q   <= refDly_d;
      fbDly_q    <= fbDly_d;
      appl_q     <= appl_d;
      err_q      <= err_d;
      band_q     <= band_d;
      low_q      <= low_d;
    end
  end

  assign refDelayPs     = refDly_q;
  assign fbDelayPs      = fbDly_q;
  assign appliedDelayPs = appl_q;
  assign cfgError       = err_q;
  assign outputBand     = band_q;
  assign lowBandMode    = low_q;

  // Lock only with legal factors
  AST_LOCK_LEGAL: assert property (@(posedge clk) disable iff (!nrst)
    ce && !cfgValid |=> !lockOut)
    else $error("locked with illegal divider factor");
  // Disable shuts the loop down next cycle
  AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!nrst)
    ce && !powerEnable |=> !lockOut && !multipliedOutput && lockCnt_q == 12'h000)
    else $error("loop still active while disabled");
  // Lock at the end of the count when feedback is active
  AST_LOCK_TIME: assert property (@(posedge clk) disable iff (!nrst)
    ce && state_q == ST_ACQUIRE && lockCnt_q == LOCK_LAST && fbSeen_q
      && powerEnable && cfgValid |=> lockOut)
    else $error("lock not reached in time");
  // Lock never rises early
  AST_NO_EARLY_LOCK: assert property (@(posedge clk) disable iff (!nrst)
    $rose(lockOut) |-> $past(lockCnt_q) == LOCK_LAST)
    else $error("lock rose before acquisition time");
  // Static delay stays put
  AST_STATIC_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    taken_q && !dynamicDelayMode ##1 !dynamicDelayMode |-> $stable(appliedDelayPs))
    else $error("static delay changed");
  // Dynamic delay follows the port by the step size and sign
  AST_DYN_FOLLOW: assert property (@(posedge clk) disable iff (!nrst)
    ce && dynamicDelayMode |=> (refDelayPs | fbDelayPs)
      == 12'($past(delayCode[3:0])) * 12'd250
      && (appliedDelayPs < 0) == ($past(delayCode[4]) && $past(delayCode[3:0]) != 4'h0))
    else $error("dynamic delay mismatch");
  // One line active at a time, within span
  AST_DELAY_SPAN: assert property (@(posedge clk) disable iff (!nrst)
    (refDelayPs == 12'h000 || fbDelayPs == 12'h000)
      && appliedDelayPs <= 13'sd3750 && appliedDelayPs >= -13'sd3750)
    else $error("delay out of span");
  // Mux passes only the selected source
  AST_FB_MUX: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> feedbackToCore == ($past(cfg.feedbackSel) ? $past(fbSync_q[1])
      : $past(mult_q)))
    else $error("feedback mux picked wrong source");

  // Relock timer, zero until lock drops, saturates at the top
  logic [12:0] relock_q, relock_d;       // Cycles since lock fell

  // Next relock count
  always_comb begin
    relock_d = relock_q;
    if (state_q == ST_LOCKED && state_d != ST_LOCKED) begin
      relock_d = 13'h0001;               // Lock drops at this edge
    end else if (relock_q != 13'h0000 && relock_q != 13'h1fff) begin
      relock_d = relock_q + 13'h0001;
    end
  end

  // Relock register, frozen while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relock_q <= 13'h0000;
    end else if (ce) begin
      relock_q <= relock_d;
    end
  end

  // Main scenarios
  COV_LOCK: cover property (@(posedge clk) disable iff (!nrst) $rose(lockOut));
  COV_EXT_LOCK: cover property (@(posedge clk) disable iff (!nrst)
    lockOut && cfg.feedbackSel);
  COV_DYN_NEG: cover property (@(posedge clk) disable iff (!nrst)
    dynamicDelayMode && appliedDelayPs < 0);
  COV_RELOCK: cover property (@(posedge clk) disable iff (!nrst)
    $rose(lockOut) && relock_q != 13'h0000 && relock_q <= 13'd4000);

endmodule

//--- verif/pcpd_pin_model.sv
// Pin-side sources for the PLL control model: reference and external feedback.
// Assumes one system clock; both pins change just after its rising edge.
`timescale 1ns/1ns
module pcpd_pin_model #(
  parameter int REF_HALF  = 32,  // Reference half period in clk cycles
  parameter int FEED_HALF = 16   // External feedback half period
) (
  // Clock
  input  wire logic clk,
  // Pins
  output logic      refIn,
  output logic      extFeedback
);
  int refCnt  = 0;  // Reference phase counter
  int feedCnt = 0;  // Feedback phase counter

  initial begin
    refIn = 1'b0;
    extFeedback = 1'b0;
  end

  // Free-running reference, slow against clk like a scaled pin oscillator
  always @(posedge clk) begin
    // Straight from a dedicated pin, so no core buffer sits in front
    if (refCnt == REF_HALF - 1) begin
      refCnt <= 0;
      refIn  <= ~refIn;
    end else begin
      refCnt <= refCnt + 1;
    end
  end

  // External feedback returning from the board at its own rate
  always @(posedge clk) begin
    if (feedCnt == FEED_HALF - 1) begin
      feedCnt     <= 0;
      extFeedback <= ~extFeedback;
    end else begin
      feedCnt <= feedCnt + 1;
    end
  end
endmodule

//--- verif/tb_top.sv
// Bench for the PLL control model: drives configuration, checks outputs.
// Assumes the pin model and the design files are compiled before it.
`timescale 1ns/1ns
`include "pcpd_regs.svh"
module tb_top
  import pcpd_pkg::*;
;
  localparam int REF_HALF  = 32;  // Reference half period, clk cycles
  localparam int FEED_HALF = 16;  // External feedback half period
  localparam int LOCK_LIM  = `PCPD_LOCK_CYCLES + 4 * REF_HALF + 8;
  // Delay code table and expected signed delay in ps
  localparam logic [4:0] DCODE [6] = '{5'h00, 5'h01, 5'h0f, 5'h13, 5'h1f, 5'h10};
  localparam int         DPS   [6] = '{0, 250, 3750, -750, -3750, 0};
  // Divider factor pairs and expected error flag
  localparam logic [6:0] BAD_I [6] = '{7'h00, 7'h41, 7'h04, 7'h04, 7'h40, 7'h01};
  localparam logic [6:0] BAD_J [6] = '{7'h02, 7'h02, 7'h00, 7'h41, 7'h40, 7'h01};
  localparam logic       BAD_E [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  // Stimulus
  logic                clk;
  logic                nrst;
  logic                ce;
  logic                refIn;
  logic                extFeedback;
  logic                powerEnable;
  pcpd_cfg_t           cfg;
  logic                dynamicDelayMode;
  logic [4:0]          delayCode;
  // Observed
  logic                dividedOutput;
  logic                multipliedOutput;
  logic                feedbackToCore;
  logic                lockOut;
  logic                cfgError;
  pcpd_band_t          outputBand;
  logic                lowBandMode;
  logic [11:0]         refDelayPs;
  logic [11:0]         fbDelayPs;
  logic signed [12:0]  appliedDelayPs;
  // Tallies
  int                  num_errors;
  int                  n_tests;

  pcpd_pin_model #(.REF_HALF(REF_HALF), .FEED_HALF(FEED_HALF)) pins (
    .clk(clk), .refIn(refIn), .extFeedback(extFeedback));

  pcpd_top dut (
    .clk(clk), .nrst(nrst), .ce(ce), .refIn(refIn),
    .externalFeedbackIn(extFeedback), .powerEnable(powerEnable), .cfg(cfg),
    .dynamicDelayMode(dynamicDelayMode), .delayCode(delayCode),
    .dividedOutput(dividedOutput), .multipliedOutput(multipliedOutput),
    .feedbackToCore(feedbackToCore), .lockOut(lockOut), .cfgError(cfgError),
    .outputBand(outputBand), .lowBandMode(lowBandMode), .refDelayPs(refDelayPs),
    .fbDelayPs(fbDelayPs), .appliedDelayPs(appliedDelayPs));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Exact value compare
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Edge count compare, one edge of slack for window phase
  task chk_near(input int got, input int exp);
    n_tests++;
    if (got < exp - 1 || got > exp + 1) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Wait n edges, then settle
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Rising edges of one output over 1024 cycles
  task cnt(input int sel, output int c);
    logic prev;
    logic cur;
    c = 0;
    prev = 1'b1;
    repeat (1024) begin
      step(1);
      cur = (sel == 0) ? multipliedOutput : (sel == 1) ? dividedOutput : feedbackToCore;
      if (cur === 1'b1 && prev === 1'b0) c++;
      prev = cur;
    end
  endtask

  // Set a delay code and check all three delay outputs
  task t_delay(input logic [4:0] code, input int ps);
    @(posedge clk);
    delayCode <= code;
    step(1);
    chk(16'(appliedDelayPs), 16'(ps));
    chk(16'(refDelayPs), 16'(ps > 0 ? ps : 0));
    chk(16'(fbDelayPs), 16'(ps < 0 ? -ps : 0));
  endtask

  // Wait for lock under a bound, return cycles taken
  task wait_lock(output int n);
    n = 0;
    step(1);
    while (lockOut !== 1'b1 && n < LOCK_LIM) begin
      step(1);
      n++;
    end
  endtask

  // Outputs while reset is held
  task t_reset;
    chk(16'(lockOut), 16'h0000);
    chk(16'(outputBand), 16'(BAND_400_1000));
    chk(16'(appliedDelayPs), 16'h0000);
  endtask

  // Code captured after reset stays put in static mode
  task t_static;
    step(3);
    chk(16'(appliedDelayPs), 16'h02ee);
    t_delay(5'h1f, 750);
  endtask

  // Every range code decodes to its band; low-band flag passes through
  task t_band;
    logic [2:0] rc;
    pcpd_band_t eb;
    for (int k = 0; k < 8; k++) begin
      rc = 3'(k);
      @(posedge clk);
      cfg.rangeCode   <= rc;
      cfg.lowBandFlag <= rc[1];
      step(1);
      eb = !rc[0] ? BAND_400_1000 : (rc[2:1] == 2'h0) ? BAND_200_400 :
           (rc[2:1] == 2'h1) ? BAND_100_200 : (rc[2:1] == 2'h2) ? BAND_50_100 : BAND_20_50;
      chk(16'(outputBand), 16'(eb));
      chk(16'(lowBandMode), 16'(rc[1]));
    end
  endtask

  // Delay follows the code port in dynamic mode, with the loop still powered down
  task t_dynamic;
    @(posedge clk);
    dynamicDelayMode <= 1'b1;
    for (int k = 0; k < 6; k++) t_delay(DCODE[k], DPS[k]);
  endtask

  // Clock enable low freezes the delay outputs, then they catch up
  task t_freeze;
    @(posedge clk);
    ce        <= 1'b0;
    delayCode <= 5'h05;
    step(3);
    chk(16'(appliedDelayPs), 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    step(1);
    chk(16'(appliedDelayPs), 16'h04e2);
  endtask

  // Lock time and both output frequencies (i=4, j=2)
  task t_lock;
    int n;
    int c;
    @(posedge clk);
    powerEnable <= 1'b1;
    wait_lock(n);
    chk(16'(lockOut), 16'h0001);
    cnt(0, c);
    chk_near(c, 1024 * 4 / (2 * REF_HALF));
    cnt(1, c);
    chk_near(c, 1024 * 4 / (2 * REF_HALF) / 2);
  endtask

  // Internal then external feedback reaches the core side
  task t_fbsel;
    int c;
    cnt(2, c);
    chk_near(c, 1024 * 4 / (2 * REF_HALF));
    @(posedge clk);
    cfg.feedbackSel <= 1'b1;
    step(4);
    cnt(2, c);
    chk_near(c, 1024 / (2 * FEED_HALF));
    @(posedge clk);
    cfg.feedbackSel <= 1'b0;
  endtask

  // Shutdown drops lock and clocks; re-enable counts again from zero
  task t_power;
    int n;
    @(posedge clk);
    powerEnable <= 1'b0;
    step(1);
    chk(16'(lockOut), 16'h0000);
    step(3);
    chk(16'({multipliedOutput, dividedOutput}), 16'h0000);
    @(posedge clk);
    powerEnable <= 1'b1;
    wait_lock(n);
    chk(16'(lockOut), 16'h0001);
    chk(16'(n >= `PCPD_LOCK_CYCLES - 8), 16'h0001);
    chk(16'(n <= `PCPD_LOCK_CYCLES), 16'h0001);
  endtask

  // Divider factors at and beyond both limits
  task t_cfg;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      cfg.fbDiv  <= BAD_I[k];
      cfg.outDiv <= BAD_J[k];
      step(1);
      chk(16'(cfgError), 16'(BAD_E[k]));
      if (k == 0) chk(16'(lockOut), 16'h0000);
    end
  endtask

  // Counts and verdict
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    powerEnable = 1'b0;
    cfg = '{fbDiv: 7'h04, outDiv: 7'h02, rangeCode: 3'h0, lowBandFlag: 1'b0,
            feedbackSel: 1'b0};
    dynamicDelayMode = 1'b0;
    delayCode = 5'h03;
    num_errors = 0;
    n_tests = 0;
    step(8);
    t_reset;
    @(posedge clk);
    nrst <= 1'b1;
    t_static;
    t_band;
    t_dynamic;
    t_freeze;
    t_lock;
    t_fbsel;
    t_power;
    t_cfg;
    end_sim;
  end

  // Hang guard, nearly four times the expected run
  initial begin
    #300000;
    num_errors++;
    end_sim;
  end
endmodule
